// ===== hdl/rss_defs.svh
// Purpose: Constants for the rotate, subtract-from-literal and sleep execution block
// Assumes: 14-bit instruction words, 8-bit data path
// Notes:   Offsets are byte addresses on the APB register bus
`ifndef RSS_DEFS_SVH
`define RSS_DEFS_SVH

// Opcode prefixes and fixed words
`define RSS_ROTL_PREFIX   6'h0D
`define RSS_ROTR_PREFIX   6'h0C
`define RSS_SUBL_PREFIX   5'h1E
`define RSS_SLEEP_WORD    14'h0063

// Register byte offsets
`define RSS_OFS_INSN      12'h000
`define RSS_OFS_ACC       12'h004
`define RSS_OFS_FILE      12'h008
`define RSS_OFS_STATUS    12'h00C
`define RSS_OFS_WDOG      12'h010

// Status bit positions
`define RSS_ST_CARRY      0
`define RSS_ST_HALF       1
`define RSS_ST_ZERO       2
`define RSS_ST_PDOWN      3
`define RSS_ST_TOUT       4

// Reset values
`define RSS_STATUS_RESET  5'h18
`define RSS_ACC_RESET     8'h00
`define RSS_WDOG_RESET    8'h00
`define RSS_PRESC_RESET   8'h00

`endif

// ===== hdl/rss_exec.sv
// Purpose: Executes rotate-through-carry, subtract-from-literal and sleep
// Assumes: APB slave, single 25 MHz clock, instruction issued by register write
// Notes:   A write to the instruction register executes it at that edge
//
// Function
// - Rotate left: carry into bit0, bit7 out
// - Destination bit selects accumulator or file register
// - Rotate right: carry into bit7, bit0 out
// - Sleep opcode enters sleep, oscillator halted
// - Sleep clears watchdog counter and prescaler
// - Sleep clears powerdown flag, sets timeout flag
// - Literal minus accumulator written to accumulator
// - Carry set when no borrow occurs
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "rss_defs.svh"

module rss_exec
  import rss_pkg::*;
(
  input  wire logic        pclk,          // 25 MHz clock
  input  wire logic        presetn,       // Async reset, active low
  input  wire logic        psel,          // APB select
  input  wire logic        penable,       // APB access phase
  input  wire logic        pwrite,        // APB direction
  input  wire logic [11:0] paddr,         // APB byte address
  input  wire logic [31:0] pwdata,        // APB write data
  input  wire logic        wake,          // Wake request from outside
  output logic      [31:0] prdata,        // APB read data
  output logic             pready,        // APB ready
  output logic             pslverr,       // APB error on unmapped address
  output logic             osc_run,       // Oscillator enable, low in sleep
  output logic      [6:0]  file_addr,     // File register address of last rotate
  output logic             file_we,       // File write-back strobe
  output logic      [7:0]  file_wdata     // File write-back data
);

  logic [7:0]  acc;          // Accumulator
  logic [7:0]  file_val;     // Operand byte of the addressed file register
  rss_flags_t  flags;        // Status flags
  logic [7:0]  watchdog_counter; // Watchdog count
  logic [7:0]  wdog_presc;   // Watchdog prescaler
  logic        sleeping;     // Sleep state
  logic        wr_en;        // APB write at access edge
  logic        rd_en;        // APB read in its setup cycle
  logic        insn_wr;      // Instruction issued this edge
  logic [13:0] insn;         // Instruction word from bus
  rss_op_t     op;           // Decoded class
  logic [7:0]  next_acc;     // Accumulator result
  logic [7:0]  rot_res;      // Rotate result
  logic        rot_carry;    // Carry out of rotate
  logic [8:0]  sub_full;     // Literal minus accumulator with borrow
  logic [4:0]  sub_low;      // Low nibble difference with borrow

  // Decode an instruction word into its class
  // Only the fixed sleep word counts; near misses decode to no operation
  function automatic rss_op_t decode_op(input logic [13:0] w);
    if (w[13:8] == `RSS_ROTL_PREFIX) begin
      decode_op = RSS_OP_ROTL;
    end else if (w[13:8] == `RSS_ROTR_PREFIX) begin
      decode_op = RSS_OP_ROTR;
    end else if (w[13:9] == `RSS_SUBL_PREFIX) begin
      decode_op = RSS_OP_SUBL;
    end else if (w == `RSS_SLEEP_WORD) begin
      decode_op = RSS_OP_SLEEP;
    end else begin
      decode_op = RSS_OP_NONE;
    end
  endfunction

  // Bus strobes; zero wait state
  // Reads are captured at the end of the setup cycle, so read data comes
  // from a flip-flop and stands for the whole access phase
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & ~penable & ~pwrite;
  assign pready  = 1'b1;
  assign insn    = pwdata[13:0];
  // Sleeping core ignores new instructions until woken
  assign insn_wr = wr_en & (paddr == `RSS_OFS_INSN) & ~sleeping;
  assign op      = decode_op(insn);
  assign osc_run = ~sleeping;

  // Unmapped address answers with an error
  // Only whole-word offsets are mapped; an offset inside a word errs too
  always_comb begin
    case (paddr)
      `RSS_OFS_INSN, `RSS_OFS_ACC, `RSS_OFS_FILE,
      `RSS_OFS_STATUS, `RSS_OFS_WDOG: pslverr = 1'b0;
      default:                        pslverr = psel & penable;
    endcase
  end

  // Rotate and subtract datapath
  // Both results are worked out every cycle; the writers below pick by class,
  // which costs a little logic but keeps each update in one cycle
  always_comb begin
    rot_res   = file_val;
    rot_carry = flags.carry;
    if (op == RSS_OP_ROTL) begin
      rot_res   = {file_val[6:0], flags.carry};
      rot_carry = file_val[7];
    end else if (op == RSS_OP_ROTR) begin
      rot_res   = {flags.carry, file_val[7:1]};
      rot_carry = file_val[0];
    end
    sub_full = {1'b0, insn[7:0]} - {1'b0, acc};
    sub_low  = {1'b0, insn[3:0]} - {1'b0, acc[3:0]};
    next_acc = (op == RSS_OP_SUBL) ? sub_full[7:0] : rot_res;
  end

  // Accumulator: rotate with dest 0, or subtract result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= `RSS_ACC_RESET;
    end else if (wr_en && paddr == `RSS_OFS_ACC && !sleeping) begin
      acc <= pwdata[7:0];
    end else if (insn_wr) begin
      case (op)
        RSS_OP_ROTL, RSS_OP_ROTR: begin
          if (!insn[7]) acc <= next_acc;
        end
        RSS_OP_SUBL: acc <= next_acc;
        default: acc <= acc;
      endcase
    end
  end

  // File operand holder and write-back port; dest 1 stores back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      file_val   <= 8'h00;
      file_addr  <= 7'h00;
      file_we    <= 1'b0;
      file_wdata <= 8'h00;
    end else begin
      file_we <= 1'b0;
      if (wr_en && paddr == `RSS_OFS_FILE && !sleeping) begin
        file_val <= pwdata[7:0];
      end else if (insn_wr && (op == RSS_OP_ROTL || op == RSS_OP_ROTR)) begin
        file_addr <= insn[6:0];
        if (insn[7]) begin
          file_val   <= rot_res;
          file_we    <= 1'b1;
          file_wdata <= rot_res;
        end
      end
    end
  end

  // Status flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= `RSS_STATUS_RESET;
    end else if (wr_en && paddr == `RSS_OFS_STATUS && !sleeping) begin
      // Powerdown and timeout stay read-only for software
      flags.carry           <= pwdata[`RSS_ST_CARRY];
      flags.half_carry_flag <= pwdata[`RSS_ST_HALF];
      flags.zero  <= pwdata[`RSS_ST_ZERO];
    end else if (insn_wr) begin
      case (op)
        RSS_OP_ROTL, RSS_OP_ROTR: flags.carry <= rot_carry;
        RSS_OP_SUBL: begin
          flags.carry           <= ~sub_full[8];
          flags.half_carry_flag <= ~sub_low[4];
          flags.zero            <= (sub_full[7:0] == 8'h00);
        end
        RSS_OP_SLEEP: begin
          flags.powerdown_flag <= 1'b0;
          flags.timeout_flag   <= 1'b1;
        end
        default: flags <= flags;
      endcase
    end
  end

  // Sleep state; wake handled outside, this only releases it
  // Sleep can only be entered while awake; a wake in the same cycle as an entry is lost, entry wins
  // Limitation: nothing here but reset restarts the core without the wake input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleeping <= 1'b0;
    end else if (insn_wr && op == RSS_OP_SLEEP) begin
      sleeping <= 1'b1;
    end else if (wake) begin
      sleeping <= 1'b0;
    end
  end

  // Watchdog counter and prescaler; run while awake, cleared by sleep
  // The prescaler divides by 256; the counter steps on its wrap
  // Clearing both on sleep gives a full period once the core wakes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_counter <= `RSS_WDOG_RESET;
      wdog_presc       <= `RSS_PRESC_RESET;
    end else if (insn_wr && op == RSS_OP_SLEEP) begin
      watchdog_counter <= 8'h00;
      wdog_presc       <= 8'h00;
    end else if (!sleeping) begin
      wdog_presc <= wdog_presc + 8'h01;
      if (wdog_presc == 8'hFF) watchdog_counter <= watchdog_counter + 8'h01;
    end
  end

  // Read data, registered at the end of the setup cycle
  // A watchdog read shows the count one cycle before the access edge;
  // that small lag was traded for read data coming from flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (paddr)
        `RSS_OFS_ACC:    prdata <= {24'h00_0000, acc};      // Accumulator
        `RSS_OFS_FILE:   prdata <= {24'h00_0000, file_val}; // File operand
        `RSS_OFS_STATUS: prdata <= {27'h000_0000, flags};   // Status flags
        `RSS_OFS_WDOG:   prdata <= {8'h00, wdog_presc, 8'h00, watchdog_counter};
        default:         prdata <= 32'h0000_0000;           // Write-only or unmapped
      endcase
    end else if (!psel) begin
      prdata <= 32'h0000_0000; // Idle bus reads as zero
    end
  end

endmodule

// ===== hdl/rss_pkg.sv
// Purpose: Types for the rotate, subtract-from-literal and sleep execution block
// Assumes: Used with rss_defs.svh
// Notes:   Opcode class enum is used by rss_exec only; the bench uses the defines
package rss_pkg;
  // Decoded instruction class
  typedef enum logic [2:0] {
    RSS_OP_NONE  = 3'h0,
    RSS_OP_ROTL  = 3'h1,
    RSS_OP_ROTR  = 3'h3,
    RSS_OP_SUBL  = 3'h2,
    RSS_OP_SLEEP = 3'h6
  } rss_op_t;

  // Status flag group
  typedef struct packed {
    logic timeout_flag;    // Set by sleep
    logic powerdown_flag;  // Cleared by sleep
    logic zero;            // Result was zero
    logic half_carry_flag; // No borrow out of the low nibble
    logic carry;           // No borrow, or rotate carry
  } rss_flags_t;
endpackage

// ===== testbench/rss_exec_monitor.sv
// Purpose: Port-level timing checks for rss_exec
// Assumes: One clock, reset asynchronous and active low
// Notes:   Sees ports only, so data results are judged by the bench
`timescale 1ns/1ps
module rss_exec_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        wake,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        osc_run,
  input wire logic [6:0]  file_addr,
  input wire logic        file_we,
  input wire logic [7:0]  file_wdata
);
  wire logic [6:0] insn_addr = pwdata[6:0]; // File address field of the opcode
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Opcode write taken; writes while asleep are refused
  sequence s_insn;
    psel && penable && pwrite && paddr == 12'h000 && osc_run;
  endsequence
  // Either rotate; the two differ only in bit 8
  sequence s_rot;
    s_insn ##0 pwdata[13:9] == 5'h06;
  endsequence
  a_rot_to_file: assert property (s_rot ##0 pwdata[7] |=> file_we && file_addr == $past(insn_addr))
    else $error("rotate to file gave no write-back");
  a_rot_to_acc: assert property (s_rot ##0 !pwdata[7] |=> !file_we)
    else $error("rotate to accumulator wrote the file");
  a_we_single: assert property (file_we |=> !file_we)
    else $error("file write strobe wider than one cycle");
  a_sleep_halt: assert property (s_insn ##0 pwdata[13:0] == 14'h0063 |=> !osc_run)
    else $error("sleep opcode left the oscillator running");
  a_sleep_hold: assert property (!osc_run && !wake |=> !osc_run)
    else $error("oscillator restarted without wake");
  a_sleep_quiet: assert property (!osc_run |-> !file_we)
    else $error("file written while asleep");
  a_wake_resume: assert property (!osc_run && wake |=> osc_run)
    else $error("wake did not restart the oscillator");
  a_bad_addr_err: assert property (psel && penable &&
    !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010}) |-> pslverr)
    else $error("unmapped access without error");
  a_good_addr_ok: assert property (psel && penable &&
    (paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010}) |-> !pslverr)
    else $error("mapped access flagged as error");
endmodule
bind rss_exec rss_exec_monitor i_rss_exec_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .wake(wake),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_run(osc_run),
  .file_addr(file_addr), .file_we(file_we), .file_wdata(file_wdata));

// ===== testbench/testbench.sv
// Purpose: Self-checking bench for rss_exec over APB
// Assumes: 25 MHz clock, reset held five cycles
// Notes:   Expected values are worked out here from the opcode semantics
`timescale 1ns/1ps
`include "rss_defs.svh"
module testbench;
  logic pclk, presetn, psel, penable, pwrite, wake, pready, pslverr, osc_run, file_we;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [6:0]  file_addr;
  logic [7:0]  file_wdata;
  logic        err_v;
  int          fail_count, cmp_count;
  rss_exec i_rss_exec (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .wake(wake), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .osc_run(osc_run), .file_addr(file_addr),
    .file_we(file_we), .file_wdata(file_wdata));
  // Compare and count; unknowns never match
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1); // Only the watchdog ends a hang
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_v, exp);
  endtask
  // Reset values and an unmapped address
  task automatic t_reset;
    rd(12'h00C, 32'h18);
    rd(12'h004, 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    chk({31'h0, err_v}, 32'h1);
  endtask
  // Left to accumulator, then right back into the file at the top address
  task automatic t_rotate;
    apb(1'b1, 12'h00C, 32'h0);
    apb(1'b1, 12'h008, 32'hE6);
    apb(1'b1, 12'h000, {18'h0, `RSS_ROTL_PREFIX, 8'h05});
    rd(12'h004, 32'hCC);
    rd(12'h00C, 32'h19);
    apb(1'b1, 12'h000, {18'h0, `RSS_ROTR_PREFIX, 8'hFF});
    @(negedge pclk);
    chk({31'h0, file_we}, 32'h1);
    chk({24'h0, file_wdata}, 32'hF3);
    chk({25'h0, file_addr}, 32'h7F);
    rd(12'h008, 32'hF3);
    rd(12'h004, 32'hCC);
    rd(12'h00C, 32'h18);
  endtask
  // Literal minus accumulator: positive, zero, negative, nibble borrow
  task automatic t_sub;
    logic [7:0] k[4] = '{8'h02, 8'h02, 8'h02, 8'h10};
    logic [7:0] w[4] = '{8'h01, 8'h02, 8'h03, 8'h01};
    logic [7:0] r[4] = '{8'h01, 8'h00, 8'hFF, 8'h0F};
    logic [7:0] f[4] = '{8'h1B, 8'h1F, 8'h18, 8'h19};
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'h004, {24'h0, w[i]});
      apb(1'b1, 12'h000, {18'h0, `RSS_SUBL_PREFIX, i[0], k[i]}); // Bit 8 is don't-care
      rd(12'h004, {24'h0, r[i]});
      rd(12'h00C, {24'h0, f[i]});
    end
  endtask
  // Sleep after the watchdog has run; writes refused until wake
  task automatic t_sleep;
    apb(1'b1, 12'h00C, 32'h5);
    repeat (300) @(posedge pclk);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, rd_v[7:0] != 8'h00}, 32'h1);
    apb(1'b1, 12'h000, {18'h0, `RSS_SLEEP_WORD});
    @(negedge pclk);
    chk({31'h0, osc_run}, 32'h0);
    rd(12'h010, 32'h0);
    rd(12'h00C, 32'h15);
    apb(1'b1, 12'h004, 32'hAA);
    rd(12'h004, 32'h0F);
    @(posedge pclk) wake <= 1'b1;
    @(posedge pclk) wake <= 1'b0;
    @(negedge pclk);
    chk({31'h0, osc_run}, 32'h1);
  endtask
  task automatic print_verdict;
    if (fail_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Free-running 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Hang guard, well beyond the few hundred cycles the run needs
  initial begin
    #(40 * 5000);
    fail_count++;
    print_verdict();
  end
  initial begin
    {presetn, psel, penable, pwrite, wake, paddr, pwdata} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_rotate();
    t_sub();
    t_sleep();
    @(posedge pclk) presetn <= 1'b0; // Second reset in mid-run
    @(posedge pclk) presetn <= 1'b1;
    rd(12'h00C, 32'h18);
    print_verdict();
  end
endmodule
